/* hdl/fdsc_top.sv */
// seek/recalibrate/scan command logic behind an AHB-Lite register slave
// assumes drive inputs synchronous to hclk, zero-wait word accesses
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module fdsc_top #(
    parameter int MS_CYCLES = fdsc_pkg::STEP_UNIT_CYCLES
) (
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic [31:0] hrdata,
    output logic        hreadyout,
    output logic        hresp,
    input  logic [3:0]  drive_ready,
    input  logic [3:0]  track_zero_input,
    output logic [3:0]  step_direction_output,
    output logic [3:0]  step_pulse_output,
    output logic        intr_req
);
    localparam int TW = $clog2(int'(fdsc_pkg::STEP_MS_BASE) * MS_CYCLES + 1);
    localparam int ND = fdsc_pkg::NDRV;

    fdsc_pkg::fdsc_seq_t seq, next_seq;
    fdsc_pkg::fdsc_ap_t  ap, next_ap;
    logic [7:0]          cb     [9];
    logic [7:0]          next_cb[9];
    logic [7:0]          res     [7];
    logic [7:0]          next_res[7];
    logic [3:0]          bcnt, next_bcnt;
    logic [2:0]          rcnt, next_rcnt, ridx, next_ridx;
    logic [3:0]          step_cfg, next_step_cfg;
    logic [31:0]         next_rdata;
    logic                next_intr, set_int;
    logic [3:0]          rdy_prev;
    logic                rdy_chg, next_rdy_chg;
    logic [1:0]          rdy_drv, next_rdy_drv;
    logic [3:0]          start_seek, start_recal, clr_end, end_evt, stepping, drive_busy;
    logic                clr_busy, rd_req, wr_data, controller_active;
    logic [7:0]          new_tgt;
    logic [TW-1:0]       iv_load;
    fdsc_pkg::fdsc_drv_t dst [ND];
    logic [7:0]          pcn [ND];
    logic [7:0]          tgt [ND];
    logic [TW-1:0]       tmr [ND];
    logic [8:0]          nst [ND];
    logic [ND-1:0]       recal, endp;
    fdsc_pkg::fdsc_end_t endi [ND];

    function automatic logic [3:0] cmd_len(input logic [7:0] op);
        if (op == fdsc_pkg::OP_SEEK) cmd_len = fdsc_pkg::LEN_SEEK;
        else if (op == fdsc_pkg::OP_RECAL) cmd_len = fdsc_pkg::LEN_RECAL;
        else if (op == fdsc_pkg::OP_SENSE) cmd_len = fdsc_pkg::LEN_SENSE;
        else if (op[4:0] == fdsc_pkg::OP_SCAN_EQ || op[4:0] == fdsc_pkg::OP_SCAN_LE
                 || op[4:0] == fdsc_pkg::OP_SCAN_HE) cmd_len = fdsc_pkg::LEN_SCAN;
        else cmd_len = 4'h0;
    endfunction

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign controller_active = (seq != fdsc_pkg::S_IDLE);
    assign rd_req = hsel && htrans[1] && hready && !hwrite && haddr[31:8] == 24'h0;
    assign wr_data = ap.valid && ap.write && ap.addr == fdsc_pkg::ADDR_DATA;
    assign iv_load = TW'((fdsc_pkg::STEP_MS_BASE - {1'b0, step_cfg}) * MS_CYCLES - 1);

    always_comb begin
        logic [3:0] len;
        logic [7:0] op;
        logic [1:0] sel;
        logic       found;
        len = 4'h0;
        op = 8'h00;
        sel = 2'h0;
        found = 1'b0;
        next_ap = '{valid: hsel && htrans[1] && hready && haddr[31:8] == 24'h0,
                    write: hwrite, addr: haddr[7:0]};
        next_seq = seq;
        next_cb = cb;
        next_bcnt = bcnt;
        next_res = res;
        next_rcnt = rcnt;
        next_ridx = ridx;
        next_step_cfg = step_cfg;
        next_rdata = 32'h0;
        next_rdy_chg = rdy_chg;
        next_rdy_drv = rdy_drv;
        start_seek = 4'h0;
        start_recal = 4'h0;
        clr_end = 4'h0;
        clr_busy = 1'b0;
        new_tgt = 8'h00;
        set_int = |end_evt;
        if (rd_req) begin
            case (haddr[7:0])
                fdsc_pkg::ADDR_DATA: begin
                    if (seq == fdsc_pkg::S_RESULT) begin
                        next_rdata = {24'h0, res[ridx]};
                        next_ridx = ridx + 3'h1;
                        if (ridx == rcnt - 3'h1) next_seq = fdsc_pkg::S_IDLE;
                    end
                end
                fdsc_pkg::ADDR_MSR:
                    next_rdata = {24'h0, 1'b1, seq == fdsc_pkg::S_RESULT, 1'b0,
                                  controller_active, drive_busy};
                fdsc_pkg::ADDR_STEP: next_rdata = {28'h0, step_cfg};
                default: next_rdata = 32'h0;
            endcase
        end
        if (ap.valid && ap.write && ap.addr == fdsc_pkg::ADDR_STEP)
            next_step_cfg = hwdata[3:0];
        if (wr_data && seq != fdsc_pkg::S_RESULT) begin
            len = cmd_len(seq == fdsc_pkg::S_IDLE ? hwdata[7:0] : cb[0]);
            if (seq == fdsc_pkg::S_IDLE && (len == 4'h0 || (|stepping
                && hwdata[7:0] != fdsc_pkg::OP_SEEK && hwdata[7:0] != fdsc_pkg::OP_RECAL)
                || (hwdata[7:0] == fdsc_pkg::OP_SENSE && !rdy_chg && !(|endp)))) begin
                next_res[0] = fdsc_pkg::ST0_INVALID;
                next_rcnt = fdsc_pkg::RES_ONE;
                next_ridx = 3'h0;
                next_seq = fdsc_pkg::S_RESULT;
            end else begin
                next_cb[bcnt] = hwdata[7:0];
                next_bcnt = bcnt + 4'h1;
                next_seq = fdsc_pkg::S_CMD;
                if (bcnt + 4'h1 == len) begin
                    op = next_cb[0];
                    sel = next_cb[1][1:0];
                    new_tgt = next_cb[2];
                    next_bcnt = 4'h0;
                    next_seq = fdsc_pkg::S_IDLE;
                    next_ridx = 3'h0;
                    if (op == fdsc_pkg::OP_SEEK) start_seek[sel] = 1'b1;
                    else if (op == fdsc_pkg::OP_RECAL) start_recal[sel] = 1'b1;
                    else if (op == fdsc_pkg::OP_SENSE) begin
                        clr_busy = 1'b1;
                        next_seq = fdsc_pkg::S_RESULT;
                        next_rcnt = fdsc_pkg::RES_SENSE;
                        if (rdy_chg) begin
                            next_rdy_chg = 1'b0;
                            next_res[0] = {fdsc_pkg::IC_READY, 4'h0, rdy_drv};
                            next_res[1] = pcn[rdy_drv];
                        end else begin
                            for (int k = ND - 1; k >= 0; k--) begin
                                if (endp[k]) begin
                                    sel = 2'(k);
                                    found = 1'b1;
                                end
                            end
                            clr_end[sel] = found;
                            next_res[0] = {endi[sel].abn ? fdsc_pkg::IC_ABN : fdsc_pkg::IC_NORMAL,
                                           1'b1, endi[sel].ec, endi[sel].nr, 1'b0, sel};
                            next_res[1] = pcn[sel];
                        end
                    end else begin
                        next_res[0] = {5'h0, next_cb[1][2:0]};
                        next_res[1] = 8'h00;
                        next_res[2] = 8'h00;
                        for (int k = 3; k < 7; k++) next_res[k] = next_cb[k - 1];
                        next_rcnt = fdsc_pkg::RES_SCAN;
                        next_seq = fdsc_pkg::S_RESULT;
                        set_int = 1'b1;
                    end
                end
            end
        end
        for (int k = 0; k < ND; k++) begin
            if (drive_ready[k] != rdy_prev[k]) begin
                next_rdy_chg = 1'b1;
                next_rdy_drv = 2'(k);
                set_int = 1'b1;
            end
        end
        // status reads leave the request standing, only data traffic clears it
        next_intr = set_int || (intr_req && !wr_data
                                && !(rd_req && haddr[7:0] == fdsc_pkg::ADDR_DATA));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq <= fdsc_pkg::S_IDLE;
            ap <= '0;
            cb <= '{default: 8'h00};
            res <= '{default: 8'h00};
            bcnt <= 4'h0;
            rcnt <= 3'h0;
            ridx <= 3'h0;
            step_cfg <= fdsc_pkg::STEP_CFG_RESET;
            hrdata <= 32'h0;
            intr_req <= 1'b0;
            rdy_prev <= 4'h0;
            rdy_chg <= 1'b0;
            rdy_drv <= 2'h0;
        end else begin
            seq <= next_seq;
            ap <= next_ap;
            cb <= next_cb;
            res <= next_res;
            bcnt <= next_bcnt;
            rcnt <= next_rcnt;
            ridx <= next_ridx;
            step_cfg <= next_step_cfg;
            hrdata <= next_rdata;
            intr_req <= next_intr;
            rdy_prev <= drive_ready;
            rdy_chg <= next_rdy_chg;
            rdy_drv <= next_rdy_drv;
        end
    end

    for (genvar i = 0; i < ND; i++) begin : g_drv
        fdsc_pkg::fdsc_drv_t next_dst;
        fdsc_pkg::fdsc_end_t next_endi;
        logic [7:0]          next_pcn, next_tgt;
        logic [TW-1:0]       next_tmr;
        logic [8:0]          next_nst;
        logic                next_recal, next_dir, next_step, next_busy, next_endp, fin;

        assign stepping[i] = (dst[i] == fdsc_pkg::D_STEP);

        always_comb begin
            next_dst = dst[i];
            next_pcn = pcn[i];
            next_tgt = tgt[i];
            next_tmr = tmr[i];
            next_nst = nst[i];
            next_recal = recal[i];
            next_dir = step_direction_output[i];
            next_step = 1'b0;
            next_busy = drive_busy[i];
            next_endi = endi[i];
            fin = 1'b0;
            if (start_seek[i] || start_recal[i]) begin
                next_busy = 1'b1;
                next_recal = start_recal[i];
                next_tgt = new_tgt;
                next_nst = 9'h000;
                next_tmr = iv_load;
                next_dst = fdsc_pkg::D_STEP;
                if (start_recal[i]) next_pcn = 8'h00;
                next_dir = start_seek[i] && new_tgt > pcn[i];
                if (!drive_ready[i]) begin
                    fin = 1'b1;
                    next_endi = '{abn: 1'b1, nr: 1'b1, ec: 1'b0};
                end else if (start_seek[i] && pcn[i] == new_tgt) begin
                    fin = 1'b1;
                    next_endi = '0;
                end
            end else if (dst[i] == fdsc_pkg::D_STEP) begin
                if (!drive_ready[i]) begin
                    fin = 1'b1;
                    next_endi = '{abn: 1'b1, nr: 1'b1, ec: 1'b0};
                end else if (recal[i] && track_zero_input[i]) begin
                    fin = 1'b1;
                    next_endi = '0;
                end else if (recal[i] && nst[i] == fdsc_pkg::RECAL_MAX) begin
                    fin = 1'b1;
                    next_endi = '{abn: 1'b1, nr: 1'b0, ec: 1'b1};
                end else if (!recal[i] && pcn[i] == tgt[i]) begin
                    fin = 1'b1;
                    next_endi = '0;
                end else if (tmr[i] == '0) begin
                    next_step = 1'b1;
                    next_nst = nst[i] + 9'h001;
                    next_tmr = iv_load;
                    if (!recal[i]) next_pcn = step_direction_output[i] ? pcn[i] + 8'h01
                                                                       : pcn[i] - 8'h01;
                end else begin
                    next_tmr = tmr[i] - TW'(1);
                end
            end
            if (fin) next_dst = fdsc_pkg::D_IDLE;
            end_evt[i] = fin;
            next_endp = fin || (endp[i] && !clr_end[i]);
            if (clr_busy && dst[i] == fdsc_pkg::D_IDLE) next_busy = 1'b0;
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                dst[i] <= fdsc_pkg::D_IDLE;
                pcn[i] <= 8'h00;
                tgt[i] <= 8'h00;
                tmr[i] <= '0;
                nst[i] <= 9'h000;
                recal[i] <= 1'b0;
                endp[i] <= 1'b0;
                endi[i] <= '0;
                drive_busy[i] <= 1'b0;
                step_direction_output[i] <= 1'b0;
                step_pulse_output[i] <= 1'b0;
            end else begin
                dst[i] <= next_dst;
                pcn[i] <= next_pcn;
                tgt[i] <= next_tgt;
                tmr[i] <= next_tmr;
                nst[i] <= next_nst;
                recal[i] <= next_recal;
                endp[i] <= next_endp;
                endi[i] <= next_endi;
                drive_busy[i] <= next_busy;
                step_direction_output[i] <= next_dir;
                step_pulse_output[i] <= next_step;
            end
        end

        property p_busy_set;
            @(posedge hclk) disable iff (!hresetn) start_seek[i] |=> drive_busy[i];
        endproperty
        a_busy_set: assert property (p_busy_set) else $error("busy bit not set");

        property p_recal_zero;
            @(posedge hclk) disable iff (!hresetn) start_recal[i] |=> pcn[i] == 8'h00;
        endproperty
        a_recal_zero: assert property (p_recal_zero) else $error("track not zeroed");

        property p_not_ready;
            @(posedge hclk) disable iff (!hresetn)
            (stepping[i] && !drive_ready[i] && !start_seek[i] && !start_recal[i])
            |=> (endp[i] && endi[i].nr && endi[i].abn && !stepping[i]);
        endproperty
        a_not_ready: assert property (p_not_ready) else $error("not ready missed");

        property p_step_in;
            @(posedge hclk) disable iff (!hresetn)
            (step_pulse_output[i] && step_direction_output[i]) |-> pcn[i] == $past(pcn[i]) + 8'h01;
        endproperty
        a_step_in: assert property (p_step_in) else $error("inward step count");

        property p_fault;
            @(posedge hclk) disable iff (!hresetn)
            ($rose(endp[i]) && endi[i].ec) |-> $past(nst[i]) == fdsc_pkg::RECAL_MAX;
        endproperty
        a_fault: assert property (p_fault) else $error("early track zero fault");

        sequence s_arrive;
            stepping[i] && !recal[i] && pcn[i] == tgt[i] && drive_ready[i];
        endsequence
        property p_done;
            @(posedge hclk) disable iff (!hresetn)
            s_arrive |=> (endp[i] && !endi[i].abn && intr_req);
        endproperty
        a_done: assert property (p_done) else $error("seek end missed");
    end

    property p_ready_irq;
        @(posedge hclk) disable iff (!hresetn) (drive_ready != rdy_prev) |=> intr_req;
    endproperty
    a_ready_irq: assert property (p_ready_irq) else $error("ready change no irq");

    sequence s_bad_cmd;
        wr_data && seq == fdsc_pkg::S_IDLE && |stepping
        && hwdata[7:0] != fdsc_pkg::OP_SEEK && hwdata[7:0] != fdsc_pkg::OP_RECAL;
    endsequence
    property p_invalid;
        @(posedge hclk) disable iff (!hresetn)
        s_bad_cmd |=> (seq == fdsc_pkg::S_RESULT && res[0] == fdsc_pkg::ST0_INVALID);
    endproperty
    a_invalid: assert property (p_invalid) else $error("command not refused");

    sequence s_scan_last;
        wr_data && seq == fdsc_pkg::S_CMD && bcnt == 4'h8 && cmd_len(cb[0]) == fdsc_pkg::LEN_SCAN;
    endsequence
    property p_scan_res;
        @(posedge hclk) disable iff (!hresetn)
        s_scan_last |=> (seq == fdsc_pkg::S_RESULT && rcnt == fdsc_pkg::RES_SCAN && intr_req);
    endproperty
    a_scan_res: assert property (p_scan_res) else $error("scan result wrong");

    property p_active;
        @(posedge hclk) disable iff (!hresetn)
        (wr_data && seq == fdsc_pkg::S_CMD && bcnt == 4'h2 && cb[0] == fdsc_pkg::OP_SEEK)
        |-> controller_active ##1 !controller_active;
    endproperty
    a_active: assert property (p_active) else $error("active flag wrong");
endmodule

/* hdl/fdsc_pkg.sv */
// constants and carrier types for the floppy seek/scan command block
// assumes a 250 MHz hclk and one AHB-Lite master on the register side
// Function
// - scan ends with seven result bytes
// - active flag high in command, low executing
// - further seeks accepted while stepping
// - other commands while stepping are invalid
// - drive not ready ends command abnormally
// - one present-track register per drive
// - direction high inward, low outward
// - step at interval, equality ends seek
// - per-drive busy bit set while seeking
// - busy bits cleared by interrupt-status query
// - recalibrate zeroes present track first
// - recalibrate steps outward until track zero
// - no track zero after 256 steps: fault
// - recalibrate overlaps and handles ready like seek
// - interrupt on entering scan result phase
// - interrupt on any drive ready change
// - interrupt when seek or recalibrate terminates
// - step interval 16 minus field milliseconds
// - query reports cause code and present track
package fdsc_pkg;
    localparam int         NDRV             = 4;
    localparam logic [7:0] ADDR_DATA        = 8'h00;
    localparam logic [7:0] ADDR_MSR         = 8'h04;
    localparam logic [7:0] ADDR_STEP        = 8'h08;
    localparam logic [7:0] OP_SEEK          = 8'h0F;
    localparam logic [7:0] OP_RECAL         = 8'h07;
    localparam logic [7:0] OP_SENSE         = 8'h08;
    localparam logic [4:0] OP_SCAN_EQ       = 5'h11;
    localparam logic [4:0] OP_SCAN_LE       = 5'h19;
    localparam logic [4:0] OP_SCAN_HE       = 5'h1D;
    localparam logic [3:0] LEN_SENSE        = 4'h1;
    localparam logic [3:0] LEN_RECAL        = 4'h2;
    localparam logic [3:0] LEN_SEEK         = 4'h3;
    localparam logic [3:0] LEN_SCAN         = 4'h9;
    localparam logic [2:0] RES_ONE          = 3'h1;
    localparam logic [2:0] RES_SENSE        = 3'h2;
    localparam logic [2:0] RES_SCAN         = 3'h7;
    localparam logic [1:0] IC_NORMAL        = 2'h0;
    localparam logic [1:0] IC_ABN           = 2'h1;
    localparam logic [1:0] IC_READY         = 2'h3;
    localparam logic [7:0] ST0_INVALID      = 8'h80;
    localparam logic [8:0] RECAL_MAX        = 9'h100;
    localparam logic [4:0] STEP_MS_BASE     = 5'h10;
    localparam logic [3:0] STEP_CFG_RESET   = 4'h0;
    localparam int         CLK_PERIOD_NS    = 4;
    localparam int         STEP_UNIT_MS     = 1;
    localparam int         STEP_UNIT_CYCLES = STEP_UNIT_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {S_IDLE, S_CMD, S_RESULT} fdsc_seq_t;
    typedef enum logic {D_IDLE, D_STEP} fdsc_drv_t;
    typedef struct packed {
        logic abn;
        logic nr;
        logic ec;
    } fdsc_end_t;
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } fdsc_ap_t;
endpackage

/* tb/fdsc_drive_model.sv */
// four floppy drives: heads follow step pulses, track zero at head 0
// assumes one-clock step pulses sampled on rising hclk
`timescale 1ns/1ps
module fdsc_drive_model (
    input  logic       hclk,
    input  logic [3:0] step_direction_output,
    input  logic [3:0] step_pulse_output,
    input  logic [3:0] ready_set,
    output logic [3:0] drive_ready,
    output logic [3:0] track_zero_input
);
    int head [4] = '{0, 0, 3, 300};
    assign drive_ready = ready_set;
    always @(posedge hclk) begin
        for (int d = 0; d < 4; d++) begin
            if (step_pulse_output[d] && step_direction_output[d]) begin
                head[d] <= head[d] + 1;
            end else if (step_pulse_output[d] && head[d] > 0) begin
                head[d] <= head[d] - 1;
            end
        end
    end
    always_comb begin
        for (int d = 0; d < 4; d++) begin
            track_zero_input[d] = (head[d] == 0);
        end
    end
endmodule

/* tb/floppy_seek_scan_command_logic_tb.sv */
// self-checking bench for the seek/scan command block
// assumes a zero-wait AHB-Lite slave and the drive model beside it
`timescale 1ns/1ps
module floppy_seek_scan_command_logic_tb;
    logic        hclk = 0;
    logic        hresetn = 0;
    logic [31:0] haddr = 0;
    logic [1:0]  htrans = 0;
    logic        hwrite = 0;
    logic [31:0] hwdata = 0;
    logic [3:0]  ready_set = 4'hF;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, intr_req;
    logic [3:0]  drive_ready, track_zero_input, step_direction_output, step_pulse_output;
    int          failures = 0;
    int          samples_checked = 0;
    int          npul [4] = '{0, 0, 0, 0};

    always #2 hclk = ~hclk;
    always @(posedge hclk) begin
        for (int d = 0; d < 4; d++) begin
            if (step_pulse_output[d] === 1'b1) npul[d]++;
        end
    end

    fdsc_top #(.MS_CYCLES(20)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .drive_ready(drive_ready), .track_zero_input(track_zero_input),
        .step_direction_output(step_direction_output),
        .step_pulse_output(step_pulse_output), .intr_req(intr_req));
    fdsc_drive_model drives (.hclk(hclk), .step_direction_output(step_direction_output),
        .step_pulse_output(step_pulse_output), .ready_set(ready_set),
        .drive_ready(drive_ready), .track_zero_input(track_zero_input));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic edge_ready;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 100);
        if (hreadyout !== 1'b1) begin
            failures++;
            finish_test();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        edge_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] b);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, b}, r);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask

    task automatic dw(input logic [7:0] b);
        wr(fdsc_pkg::ADDR_DATA, b);
    endtask

    task automatic dr(input logic [31:0] exp);
        rc(fdsc_pkg::ADDR_DATA, exp);
    endtask

    task automatic wait_irq(input int bound);
        int i;
        i = 0;
        while (intr_req !== 1'b1 && i < bound) begin
            @(posedge hclk);
            i++;
        end
        if (intr_req !== 1'b1) begin
            failures++;
            finish_test();
        end
    endtask

    task automatic query(input logic [7:0] st0, input logic [7:0] trk);
        dw(fdsc_pkg::OP_SENSE);
        dr({24'h0, st0});
        dr({24'h0, trk});
    endtask

    task automatic t_reset;
        logic [31:0] r;
        rc(fdsc_pkg::ADDR_MSR, 32'h80);
        rc(fdsc_pkg::ADDR_STEP, 32'h0);
        rc(8'h10, 32'h0);
        wait_irq(20);
        dw(fdsc_pkg::OP_SENSE);
        bus(1'b0, fdsc_pkg::ADDR_DATA, 32'h0, r);
        chk(r & 32'hFC, 32'hC0);
        dr(32'h0);
        dw(fdsc_pkg::OP_SENSE);
        dr(32'h80);
        $display("reset and ready test done");
    endtask

    task automatic t_seek;
        wr(fdsc_pkg::ADDR_STEP, 8'h0F);
        rc(fdsc_pkg::ADDR_STEP, 32'hF);
        dw(fdsc_pkg::OP_SEEK);
        rc(fdsc_pkg::ADDR_MSR, 32'h90);
        dw(8'h01);
        dw(8'h02);
        rc(fdsc_pkg::ADDR_MSR, 32'h82);
        chk({31'h0, step_direction_output[1]}, 1);
        dw({3'h0, fdsc_pkg::OP_SCAN_EQ});
        dr(32'h80);
        wait_irq(200);
        chk(npul[1], 2);
        query(8'h21, 8'h02);
        rc(fdsc_pkg::ADDR_MSR, 32'h80);
        dw(fdsc_pkg::OP_SEEK);
        dw(8'h01);
        dw(8'h01);
        @(negedge hclk);
        chk({31'h0, step_direction_output[1]}, 0);
        dw(fdsc_pkg::OP_SEEK);
        dw(8'h00);
        dw(8'h03);
        wait_irq(200);
        repeat (80) @(posedge hclk);
        rc(fdsc_pkg::ADDR_MSR, 32'h83);
        query(8'h20, 8'h03);
        query(8'h21, 8'h01);
        $display("seek test done");
    endtask

    task automatic t_scan;
        logic [7:0] ops [3];
        ops = '{{3'h7, fdsc_pkg::OP_SCAN_EQ}, {3'h0, fdsc_pkg::OP_SCAN_LE},
                {3'h5, fdsc_pkg::OP_SCAN_HE}};
        for (int k = 0; k < 3; k++) begin
            dw(ops[k]);
            dw(8'h05);
            for (int i = 0; i < 7; i++) dw(8'h0A + i[7:0]);
            @(posedge hclk);
            chk({31'h0, intr_req}, 1);
            dr(32'h05);
            dr(32'h0);
            dr(32'h0);
            for (int i = 0; i < 4; i++) dr(32'hA + i);
        end
        $display("scan test done");
    endtask

    task automatic t_recal;
        dw(fdsc_pkg::OP_RECAL);
        dw(8'h03);
        dw(fdsc_pkg::OP_RECAL);
        dw(8'h00);
        @(negedge hclk);
        chk({31'h0, step_direction_output[0]}, 0);
        wait_irq(200);
        dr(32'h0);
        wait_irq(6000);
        chk(npul[0], 6);
        chk(npul[3], 256);
        query(8'h20, 8'h00);
        query(8'h73, 8'h00);
        rc(8'h10, 32'h0);
        $display("recalibrate test done");
    endtask

    task automatic t_not_ready;
        ready_set <= 4'hE;
        wait_irq(20);
        query(8'hC0, 8'h00);
        dw(fdsc_pkg::OP_SEEK);
        dw(8'h00);
        dw(8'h05);
        wait_irq(50);
        query(8'h68, 8'h00);
        $display("not-ready test done");
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_seek();
        t_scan();
        t_recal();
        t_not_ready();
        finish_test();
    end
endmodule
